/* pkg/analog_input_pkg.sv */
package analog_input_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int TEST_TIME_NS  = 1_600_000;
    // least time: round up to whole cycles
    localparam int TEST_CYCLES   = (TEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // channel data
    localparam int MAX_CHANNELS     = 16;
    localparam int WORD_WIDTH       = 16;
    localparam int VALUE_WIDTH      = 12;
    localparam int WORD_OVER_BIT    = 0;
    localparam int WORD_OPEN_BIT    = 1;
    localparam int WORD_ACTIVE_BIT  = 2;
    localparam int WORD_VALUE_LSB   = 4;

    // mode switch fields
    localparam int MODE_SELECTIVE_BIT = 0;
    localparam int MODE_CH16_BIT      = 1;
    localparam int MODE_OPEN_LSB      = 2;
    localparam logic [1:0] OPEN_HALF  = 2'h1;
    localparam logic [1:0] OPEN_ALL   = 2'h2;

    // register map, byte addresses
    localparam logic [7:0] CTRL_OFFSET       = 8'h00;
    localparam logic [7:0] STATUS_OFFSET     = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h0C;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h10;
    localparam logic [7:0] ACTIVE_OFFSET     = 8'h14;

    // field positions
    localparam int CTRL_PAUSE_BIT     = 0;
    localparam int STATUS_BUSY_BIT    = 0;
    localparam int STATUS_GATE_BIT    = 1;
    localparam int STATUS_SEL_BIT     = 2;
    localparam int STATUS_CH16_BIT    = 3;
    localparam int STATUS_CHANNEL_LSB = 4;
    localparam int STATUS_ADDR_LSB    = 8;
    localparam int STATUS_MODE_LSB    = 16;
    localparam int EV_DONE_BIT        = 0;
    localparam int EV_OPEN_BIT        = 1;
    localparam int EV_OVER_BIT        = 2;
    localparam int EV_REFUSED_BIT     = 3;
    localparam int EV_WIDTH           = 4;

    // reset values
    localparam logic                CTRL_PAUSE_RESET = 1'b0;
    localparam logic [EV_WIDTH-1:0] IRQ_RESET        = 4'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {SEQ_IDLE, SEQ_TEST, SEQ_START, SEQ_WAIT} seq_state_t;

endpackage : analog_input_pkg

/* core/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage;

    // first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage <= '0;
            q     <= '0;
        end else begin
            stage <= d;
            q     <= stage;
        end
    end
endmodule : pin_sync

/* core/analog_input_sampling_control.sv */
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module analog_input_sampling_control
    import analog_input_pkg::*;
#(
    parameter int TEST_COUNT = TEST_CYCLES
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite register slave
    input  wire logic [7:0]             awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [7:0]             araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    output logic                        irq,
    // backplane byte port, synchronous to aclk
    input  wire logic                   bp_req,
    input  wire logic                   bp_write,
    input  wire logic [7:0]             bp_addr,
    output logic [7:0]                  bp_rdata,
    output logic                        bp_ack,
    // pins
    input  wire logic                   enable_voltage,
    input  wire logic                   enable_jumper_fitted,
    input  wire logic [5:0]             address_switch,
    input  wire logic [7:0]             mode_switch_a,
    input  wire logic [7:0]             mode_switch_b,
    input  wire logic                   test_current_disable,
    // converter front end
    input  wire logic                   conv_done,
    input  wire logic                   conv_overflow,
    input  wire logic                   open_limit,
    input  wire logic [VALUE_WIDTH-1:0] conv_value,
    output logic                        conv_start,
    output logic [3:0]                  conv_channel,
    output logic                        test_current
);
    localparam int SYNC_W = 28 + VALUE_WIDTH;

    logic [SYNC_W-1:0]      sync_q;
    logic                   enable_s;
    logic                   jumper_s;
    logic [5:0]             addr_sw_s;
    logic [7:0]             mode_a_s;
    logic [7:0]             mode_b_s;
    logic                   test_disable_s;
    logic                   done_s;
    logic                   over_s;
    logic                   open_s;
    logic [VALUE_WIDTH-1:0] value_s;

    pin_sync #(.WIDTH(SYNC_W)) u_pin_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({enable_voltage, enable_jumper_fitted, address_switch, mode_switch_a,
                   mode_switch_b, test_current_disable, conv_done, conv_overflow,
                   open_limit, conv_value}),
        .q       (sync_q)
    );
    assign {enable_s, jumper_s, addr_sw_s, mode_a_s, mode_b_s, test_disable_s,
            done_s, over_s, open_s, value_s} = sync_q;

    function automatic logic decode_hit(input logic [7:0] addr, input logic [7:0] base,
                                        input logic ch16, input logic selective);
        logic [7:0] mask;
        mask = ch16 ? 8'hE0 : 8'hF0;
        // cyclic any base, selective high half
        decode_hit = ((addr & mask) == (base & mask)) && (!selective || base[7]);
    endfunction : decode_hit

    function automatic logic open_enabled(input logic [3:0] ch, input logic ch16,
                                          input logic [1:0] mode);
        logic [3:0] half;
        half = ch16 ? 4'h8 : 4'h4;
        open_enabled = (mode == OPEN_ALL) || ((mode == OPEN_HALF) && (ch < half));
    endfunction : open_enabled

    function automatic logic [3:0] lowest_set(input logic [MAX_CHANNELS-1:0] vec);
        lowest_set = 4'h0;
        for (int i = MAX_CHANNELS - 1; i >= 0; i--) begin
            if (vec[i]) begin
                lowest_set = 4'(i);
            end
        end
    endfunction : lowest_set

    logic       selective;
    logic       ch16;
    logic [1:0] open_mode;
    logic [7:0] base_addr;
    logic       gate_ok;
    assign selective = mode_a_s[MODE_SELECTIVE_BIT];
    assign ch16      = mode_a_s[MODE_CH16_BIT];
    assign open_mode = mode_a_s[MODE_OPEN_LSB +: 2];
    assign base_addr = {addr_sw_s, 2'h0};
    assign gate_ok   = !jumper_s || enable_s;

    // backplane side; no inhibit input is decoded anywhere
    logic                    bp_req_d;
    logic                    bp_hit;
    logic [3:0]              bp_channel;
    logic [7:0]              next_bp_rdata;
    logic                    next_bp_ack;
    logic                    trigger;
    logic                    ev_refused;
    logic [WORD_WIDTH-1:0]   results [MAX_CHANNELS];
    logic [MAX_CHANNELS-1:0] active;
    logic [WORD_WIDTH-1:0]   read_word;

    assign bp_hit     = decode_hit(bp_addr, base_addr, ch16, selective);
    assign bp_channel = ch16 ? bp_addr[4:1] : {1'b0, bp_addr[3:1]};

    always_comb begin
        read_word = results[bp_channel];
        read_word[WORD_ACTIVE_BIT] = active[bp_channel];
        next_bp_ack   = 1'b0;
        next_bp_rdata = bp_rdata;
        trigger       = 1'b0;
        ev_refused    = bp_req && !bp_req_d && bp_hit && !gate_ok;
        if (bp_req && !bp_ack && bp_hit && gate_ok) begin
            next_bp_ack = 1'b1;
            if (bp_write) begin
                trigger = selective;
            end else begin
                // high byte even, low byte odd
                next_bp_rdata = bp_addr[0] ? read_word[7:0] : read_word[15:8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bp_req_d <= 1'b0;
            bp_ack   <= 1'b0;
            bp_rdata <= 8'h00;
        end else begin
            bp_req_d <= bp_req;
            bp_ack   <= next_bp_ack;
            bp_rdata <= next_bp_rdata;
        end
    end

    // conversion sequencer
    seq_state_t              state;
    seq_state_t              next_state;
    logic [3:0]              channel;
    logic [3:0]              next_channel;
    logic [3:0]              scan_channel;
    logic [3:0]              next_scan_channel;
    logic [15:0]             count;
    logic [15:0]             next_count;
    logic                    open_seen;
    logic                    next_open_seen;
    logic                    next_conv_start;
    logic                    next_test_current;
    logic [MAX_CHANNELS-1:0] next_active;
    logic                    store;
    logic [WORD_WIDTH-1:0]   store_word;
    logic                    ev_done;
    logic                    ev_open;
    logic                    ev_over;
    logic                    pause;
    logic [3:0]              pick;
    logic                    go;

    always_comb begin
        next_state        = state;
        next_channel      = channel;
        next_scan_channel = scan_channel;
        next_count        = count;
        next_open_seen    = open_seen;
        next_conv_start   = 1'b0;
        next_test_current = test_current;
        next_active       = active;
        store             = 1'b0;
        store_word        = '0;
        ev_done           = 1'b0;
        ev_open           = 1'b0;
        ev_over           = 1'b0;
        pick              = selective ? lowest_set(active) : scan_channel;
        go                = selective ? (|active) : !pause;
        case (state)
            SEQ_IDLE: begin
                if (go) begin
                    next_channel   = pick;
                    next_open_seen = 1'b0;
                    next_count     = 16'h0000;
                    if (open_enabled(pick, ch16, open_mode) && !test_disable_s) begin
                        next_test_current = 1'b1;
                        next_state        = SEQ_TEST;
                    end else begin
                        next_state = SEQ_START;
                    end
                end
            end
            SEQ_TEST: begin
                next_count = count + 16'h0001;
                if (count == 16'(TEST_COUNT - 1)) begin
                    next_open_seen    = open_s;
                    next_test_current = 1'b0;
                    next_state        = SEQ_START;
                end
            end
            SEQ_START: begin
                // wait out a stale done before starting
                if (!done_s) begin
                    next_conv_start = 1'b1;
                    next_state      = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (done_s) begin
                    store = 1'b1;
                    if (open_seen) begin
                        store_word[WORD_OPEN_BIT] = 1'b1;
                    end else begin
                        store_word[WORD_VALUE_LSB +: VALUE_WIDTH] = value_s;
                        store_word[WORD_OVER_BIT] = over_s;
                    end
                    ev_done = 1'b1;
                    ev_open = open_seen;
                    ev_over = !open_seen && over_s;
                    next_active[channel] = 1'b0;
                    if (scan_channel >= (ch16 ? 4'hF : 4'h7)) begin
                        next_scan_channel = 4'h0;
                    end else begin
                        next_scan_channel = scan_channel + 4'h1;
                    end
                    next_state = SEQ_IDLE;
                end
            end
            default: begin
                next_state = SEQ_IDLE;
            end
        endcase
        // a retrigger in the store cycle keeps the flag set
        if (trigger) begin
            next_active[bp_channel] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state        <= SEQ_IDLE;
            channel      <= 4'h0;
            scan_channel <= 4'h0;
            count        <= 16'h0000;
            open_seen    <= 1'b0;
            conv_start   <= 1'b0;
            test_current <= 1'b0;
            active       <= '0;
        end else begin
            state        <= next_state;
            channel      <= next_channel;
            scan_channel <= next_scan_channel;
            count        <= next_count;
            open_seen    <= next_open_seen;
            conv_start   <= next_conv_start;
            test_current <= next_test_current;
            active       <= next_active;
        end
    end

    assign conv_channel = channel;

    // result memory keeps the latest word per channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < MAX_CHANNELS; i++) begin
                results[i] <= '0;
            end
        end else if (store) begin
            results[channel] <= store_word;
        end
    end

    // axi4-lite register file
    logic                aw_held;
    logic                next_aw_held;
    logic [7:0]          aw_addr;
    logic [7:0]          next_aw_addr;
    logic                w_held;
    logic                next_w_held;
    logic [7:0]          w_byte;
    logic [7:0]          next_w_byte;
    logic                w_lane;
    logic                next_w_lane;
    logic                next_bvalid;
    logic [1:0]          next_bresp;
    logic                next_rvalid;
    logic [31:0]         next_rdata;
    logic [1:0]          next_rresp;
    logic                next_pause;
    logic [EV_WIDTH-1:0] irq_status;
    logic [EV_WIDTH-1:0] next_irq_status;
    logic [EV_WIDTH-1:0] irq_enable;
    logic [EV_WIDTH-1:0] next_irq_enable;
    logic [EV_WIDTH-1:0] clear_mask;
    logic [EV_WIDTH-1:0] events;
    logic [31:0]         status_word;

    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    assign arready = !rvalid;
    assign irq     = |(irq_status & irq_enable);

    always_comb begin
        events                  = '0;
        events[EV_DONE_BIT]     = ev_done;
        events[EV_OPEN_BIT]     = ev_open;
        events[EV_OVER_BIT]     = ev_over;
        events[EV_REFUSED_BIT]  = ev_refused;
        status_word                              = '0;
        status_word[STATUS_BUSY_BIT]             = (state != SEQ_IDLE);
        status_word[STATUS_GATE_BIT]             = gate_ok;
        status_word[STATUS_SEL_BIT]              = selective;
        status_word[STATUS_CH16_BIT]             = ch16;
        status_word[STATUS_CHANNEL_LSB +: 4]     = channel;
        status_word[STATUS_ADDR_LSB +: 6]        = addr_sw_s;
        status_word[STATUS_MODE_LSB +: 16]       = {mode_b_s, mode_a_s};
        next_aw_held    = aw_held;
        next_aw_addr    = aw_addr;
        next_w_held     = w_held;
        next_w_byte     = w_byte;
        next_w_lane     = w_lane;
        next_bvalid     = bvalid;
        next_bresp      = bresp;
        next_rvalid     = rvalid;
        next_rdata      = rdata;
        next_rresp      = rresp;
        next_pause      = pause;
        next_irq_enable = irq_enable;
        clear_mask      = '0;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_byte = wdata[7:0];
            next_w_lane = wstrb[0];
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            case (aw_addr)
                CTRL_OFFSET: begin
                    if (w_lane) begin
                        next_pause = w_byte[CTRL_PAUSE_BIT];
                    end
                end
                IRQ_CLEAR_OFFSET: begin
                    if (w_lane) begin
                        clear_mask = w_byte[EV_WIDTH-1:0];
                    end
                end
                IRQ_ENABLE_OFFSET: begin
                    if (w_lane) begin
                        next_irq_enable = w_byte[EV_WIDTH-1:0];
                    end
                end
                STATUS_OFFSET, IRQ_STATUS_OFFSET, ACTIVE_OFFSET: begin
                    next_bresp = RESP_OKAY;
                end
                default: begin
                    next_bresp = RESP_SLVERR;
                end
            endcase
        end
        // hardware set wins over software clear
        next_irq_status = (irq_status & ~clear_mask) | events;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            case (araddr)
                CTRL_OFFSET:       next_rdata = 32'(pause);
                STATUS_OFFSET:     next_rdata = status_word;
                IRQ_STATUS_OFFSET: next_rdata = 32'(irq_status);
                IRQ_CLEAR_OFFSET:  next_rdata = 32'h0000_0000;
                IRQ_ENABLE_OFFSET: next_rdata = 32'(irq_enable);
                ACTIVE_OFFSET:     next_rdata = 32'(active);
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held    <= 1'b0;
            aw_addr    <= 8'h00;
            w_held     <= 1'b0;
            w_byte     <= 8'h00;
            w_lane     <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= RESP_OKAY;
            rvalid     <= 1'b0;
            rdata      <= 32'h0000_0000;
            rresp      <= RESP_OKAY;
            pause      <= CTRL_PAUSE_RESET;
            irq_status <= IRQ_RESET;
            irq_enable <= IRQ_RESET;
        end else begin
            aw_held    <= next_aw_held;
            aw_addr    <= next_aw_addr;
            w_held     <= next_w_held;
            w_byte     <= next_w_byte;
            w_lane     <= next_w_lane;
            bvalid     <= next_bvalid;
            bresp      <= next_bresp;
            rvalid     <= next_rvalid;
            rdata      <= next_rdata;
            rresp      <= next_rresp;
            pause      <= next_pause;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
        end
    end
endmodule : analog_input_sampling_control

/* tb/asc_properties.sv */
`timescale 1ns/10ps
module asc_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic bp_req,
    input wire logic bp_ack,
    input wire logic enable_voltage,
    input wire logic enable_jumper_fitted,
    input wire logic test_current_disable,
    input wire logic test_current,
    input wire logic conv_start,
    input wire logic bvalid,
    input wire logic awready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence test_s; test_current [*8] ##1 !test_current; endsequence
    gate_off_a: assert property ((enable_jumper_fitted && !enable_voltage) [*4] |-> !bp_ack)
        else $error("gated ack");
    ack_cause_a: assert property ($rose(bp_ack) |-> $past(bp_req)) else $error("no req");
    ack_pulse_a: assert property (bp_ack |=> !bp_ack) else $error("long ack");
    test_len_a: assert property ($rose(test_current) |-> test_s) else $error("test len");
    test_off_a: assert property (test_current_disable [*6] |-> !$rose(test_current))
        else $error("test on");
    start_clear_a: assert property (test_current |-> !conv_start) else $error("start");
    start_pulse_a: assert property (conv_start |=> !conv_start) else $error("long start");
    aw_block_a: assert property (bvalid |-> !awready) else $error("aw open");
endmodule : asc_properties
bind analog_input_sampling_control asc_properties u_props (.aclk, .aresetn, .bp_req, .bp_ack,
    .enable_voltage, .enable_jumper_fitted, .test_current_disable, .test_current,
    .conv_start, .bvalid, .awready);

/* tb/cpu_model.sv */
`timescale 1ns/10ps
module cpu_model (
    input  wire logic       aclk,
    input  wire logic       bp_ack,
    input  wire logic [7:0] bp_rdata,
    output logic            bp_req,
    output logic            bp_write,
    output logic [7:0]      bp_addr
);
    initial {bp_req, bp_write, bp_addr} = 10'h000;
    task automatic acc(input logic w, input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'h0;
        @(posedge aclk);
        bp_req <= 1'h1;
        bp_write <= w;
        bp_addr <= a;
        for (int i = 0; i < 30 && !ok; i++) begin
            @(posedge aclk);
            ok = bp_ack;
        end
        d = bp_rdata;
        bp_req <= 1'h0;
        bp_addr <= ~a;
    endtask : acc
endmodule : cpu_model

/* tb/analog_input_sampling_control_tb.sv */
`timescale 1ns/10ps
module analog_input_sampling_control_tb import analog_input_pkg::*; ;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, opn = 1'h1;
    logic arvalid = 1'h0, rready = 1'h0, enable_voltage = 1'h1, enable_jumper_fitted = 1'h1;
    logic test_current_disable = 1'h0, conv_done = 1'h0, conv_overflow = 1'h0, open_limit = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, bp_req, bp_write, bp_ack, conv_start;
    logic test_current, ok;
    logic [1:0] bresp, rresp, rs, bs;
    logic [3:0] wstrb = 4'hf, conv_channel, cnt = 4'h0;
    logic [5:0] address_switch = 6'h00;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, mode_switch_a = 8'h04, mode_switch_b = 8'h5a;
    logic [7:0] bp_addr, bp_rdata, b, base;
    logic [11:0] conv_value = 12'h000;
    logic [15:0] m [16];
    logic [31:0] wdata = 32'h0000_0000, rdata, rv, rw;
    int seed = 32'h9e78, checked = 0, miscompares = 0, cyc = 0, n = 0;
    analog_input_sampling_control #(.TEST_COUNT(8)) u_dut (.*);
    cpu_model u_cpu (.*);
    always #20 aclk = ~aclk;
    always @(posedge aclk) if (++cyc == 5000) end_sim;
    // expected word fixed as the converter starts; lower half tested only
    always @(posedge aclk) begin
        if (conv_start) begin
            rv = $random(seed);
            {open_limit, conv_overflow, conv_value} <= rv[13:0];
            m[conv_channel] <= opn && open_limit && conv_channel < 4'h4 ? 16'h0002
                               : {rv[11:0], 3'h0, rv[12]};
            n <= n + 1;
            cnt <= 4'h8;
        end else if (cnt != 4'h0) cnt <= cnt - 4'h1;
        conv_done <= cnt > 4'h1 && cnt < 4'h5;
    end
    task automatic chk(input logic [31:0] s, e, input string w);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bs = bresp;
        bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        while (!rvalid) @(posedge aclk);
        rready <= 1'h0;
        {rs, rw} = {rresp, rdata};
    endtask : rd
    task automatic end_sim;
        if (cyc >= 5000) miscompares++;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        rv = $random(seed);
        address_switch <= rv[5:0];
        base = {rv[5:0], 2'h0} & 8'hf0;
        rd(8'h40);
        chk(rs, RESP_SLVERR, "unmapped");
        wr(8'h40, 32'h0000_0000);
        chk(bs, RESP_SLVERR, "unmapped write");
        repeat (600) @(posedge aclk);
        wr(CTRL_OFFSET, 32'h0000_0001);
        chk(bs, RESP_OKAY, "write resp");
        repeat (60) @(posedge aclk);
        for (int c = 0; c < 16; c++) begin
            u_cpu.acc(1'h0, base + 8'(c), b, ok);
            chk({ok, b}, {1'h1, c[0] ? m[c / 2][7:0] : m[c / 2][15:8]}, "byte");
        end
        $display("cyclic done");
        // disable wins although open test is on
        {opn, mode_switch_a, test_current_disable, address_switch} <= {1'h0, 8'h09, 1'h1, 6'h20};
        repeat (5) @(posedge aclk);
        wr(CTRL_OFFSET, 32'h0000_0000);
        n = 0;
        repeat (50) @(posedge aclk);
        chk(n, 0, "no trigger");
        u_cpu.acc(1'h1, 8'h86, b, ok);
        u_cpu.acc(1'h0, 8'h87, b, ok);
        chk(b[2], 1'h1, "active");
        for (int i = 0; i < 40 && b[2]; i++) u_cpu.acc(1'h0, 8'h87, b, ok);
        chk({n[7:0], b}, {8'h01, m[3][7:0]}, "selective");
        address_switch <= 6'h1c;
        repeat (5) @(posedge aclk);
        u_cpu.acc(1'h0, 8'h70, b, ok);
        chk(ok, 1'h0, "low base");
        $display("selective done");
        {address_switch, enable_voltage} <= {6'h20, 1'h0};
        wr(IRQ_ENABLE_OFFSET, 32'h0000_0008);
        u_cpu.acc(1'h0, 8'h80, b, ok);
        rd(IRQ_STATUS_OFFSET);
        chk({irq, rw[3], ok}, 3'h6, "gated");
        wr(IRQ_CLEAR_OFFSET, 32'h0000_0008);
        chk(irq, 1'h0, "cleared");
        enable_jumper_fitted <= 1'h0;
        repeat (5) @(posedge aclk);
        u_cpu.acc(1'h0, 8'h80, b, ok);
        chk(ok, 1'h1, "jumper open");
        $display("gating done");
        end_sim;
    end
endmodule : analog_input_sampling_control_tb
